// ### inc/ess_pkg.sv
/*
 * Package for the engine start/stop sequencer: state codes, passcode constants,
 * timer widths and the one-second time base.
 * Assumes a single 40 MHz controller clock.
 */
package ess_pkg;
    // ==========================================================
    // time base
    localparam int CLK_HZ = 40000000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_S;
    localparam int SEC_W = 17;
    localparam int HOLD_SECONDS = 2;
    localparam int DOUBLE_SECONDS = 1;
    // ==========================================================
    // passcode
    localparam int DIGITS = 4;
    localparam logic [15:0] CODE_CLEAR = 16'h0000;
    // ==========================================================
    // sequencer states
    typedef enum logic [21:0] {
        S_STABILIZE  = 22'h000001,
        S_STOPPED    = 22'h000002,
        S_STANDBY    = 22'h000004,
        S_WAIT_START = 22'h000008,
        S_AUTO_START = 22'h000010,
        S_PRESTART1  = 22'h000020,
        S_SAFE_CHECK = 22'h000040,
        S_PRESTART2  = 22'h000080,
        S_CRANK      = 22'h000100,
        S_CRANK_REST = 22'h000200,
        S_FALSE_CHK  = 22'h000400,
        S_WARMUP     = 22'h000800,
        S_FILL1      = 22'h001000,
        S_FILL2      = 22'h002000,
        S_RUNNING    = 22'h004000,
        S_AUTO_STOP  = 22'h008000,
        S_COOLDOWN   = 22'h010000,
        S_ETS        = 22'h020000,
        S_SPINDOWN   = 22'h040000,
        S_FAULT      = 22'h080000,
        S_SPARE0     = 22'h100000,
        S_SPARE1     = 22'h200000
    } ess_state_type;
    // timer select index into the duration table
    localparam int T_STAB = 0;
    localparam int T_STOP = 1;
    localparam int T_STBY = 2;
    localparam int T_PRE1 = 3;
    localparam int T_PRE2 = 4;
    localparam int T_CRNK = 5;
    localparam int T_REST = 6;
    localparam int T_WARM = 7;
    localparam int T_FIL1 = 8;
    localparam int T_FIL2 = 9;
    localparam int T_COOL = 10;
    localparam int T_ETS = 11;
    localparam int T_SPIN = 12;
    localparam int T_ASTA = 13;
    localparam int T_ASTO = 14;
    localparam int NTIMERS = 15;
endpackage

// ### design/ess_tick.sv
/*
 * One-second tick generator: a one-cycle pulse every TICK_CYCLES clocks.
 * Assumes clk at the package rate.
 */
`timescale 1ns/1ps
module ess_tick
    import ess_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // tick out
    output logic tick
);
    logic [31:0] count;
    wire logic wrap = (count == 32'(CYCLES - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 32'h00000000;
            tick <= 1'b0;
        end else begin
            count <= wrap ? 32'h00000000 : count + 32'h00000001;
            tick <= wrap;
        end
    end
endmodule

// ### design/ess_sync.sv
/*
 * Three-stage synchroniser for one pin input; the output changes only
 * once the second and third stages agree.
 * Assumes an asynchronous source.
 */
`timescale 1ns/1ps
module ess_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pin and clean level
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule

// ### design/ess_sequencer.sv
/*
 * Engine start/stop sequencer top: state machine, delay timers, mode keys,
 * passcode entry and settings gate.
 * Assumes keys and contacts arrive as raw pins, durations as static
 * settings in seconds, and engine status flags from the same clock.
 */
`timescale 1ns/1ps
module ess_sequencer
    import ess_pkg::*;
#(
    parameter int TICK = TICK_CYCLES,
    parameter int SPEED_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // operator key pins and auto start contact
    input wire logic key_start_pin,
    input wire logic key_stop_pin,
    input wire logic key_auto_pin,
    input wire logic key_enter_pin,
    input wire logic auto_start_pin,
    // passcode entry
    input wire logic [3:0] digit_value,
    input wire logic menu_open,
    input wire logic [15:0] passcode,
    input wire logic aftertreat_menu,
    input wire logic setting_write,
    // programmed durations, seconds, zero means skip
    input wire logic [NTIMERS*SEC_W-1:0] durations,
    input wire logic crank_through,
    // engine status
    input wire logic engine_not_ready,
    input wire logic safe_to_start,
    input wire logic engine_started,
    input wire logic above_cutout,
    input wire logic fault,
    input wire logic link_ok,
    input wire logic fill1_reached,
    input wire logic fill2_reached,
    input wire logic [SPEED_W-1:0] warmup_speed,
    input wire logic [SPEED_W-1:0] min_speed,
    // outputs
    output ess_state_type state,
    output logic auto_mode,
    output logic prestart_out,
    output logic ecu_enable,
    output logic crank_out,
    output logic backlight_on,
    output logic heater_on,
    output logic transceiver_on,
    output logic [SPEED_W-1:0] speed_cmd,
    output logic speed_cmd_valid,
    output logic confirm_pending,
    output logic [15:0] code_entry,
    output logic unlocked,
    output logic setting_accept
);
    // ==========================================================
    // inputs and time base
    logic k_start;
    logic k_stop;
    logic k_auto;
    logic k_enter;
    logic auto_req;
    logic tick;
    logic k_start_d;
    logic k_stop_d;
    logic k_auto_d;
    logic k_enter_d;

    ess_sync u_s0 (.clk(clk), .rst_b(rst_b), .pin(key_start_pin), .level(k_start));
    ess_sync u_s1 (.clk(clk), .rst_b(rst_b), .pin(key_stop_pin), .level(k_stop));
    ess_sync u_s2 (.clk(clk), .rst_b(rst_b), .pin(key_auto_pin), .level(k_auto));
    ess_sync u_s3 (.clk(clk), .rst_b(rst_b), .pin(key_enter_pin), .level(k_enter));
    ess_sync u_s4 (.clk(clk), .rst_b(rst_b), .pin(auto_start_pin), .level(auto_req));
    ess_tick #(.CYCLES(TICK)) u_tick (.clk(clk), .rst_b(rst_b), .tick(tick));

    wire logic p_start = k_start & ~k_start_d;
    wire logic p_stop = k_stop & ~k_stop_d;
    wire logic p_auto = k_auto & ~k_auto_d;
    wire logic p_enter = k_enter & ~k_enter_d;

    // ==========================================================
    // timer
    logic [SEC_W-1:0] secs;
    logic stop_key_cmd;
    logic skip_cool;
    logic [SEC_W-1:0] hold_secs;
    logic [SEC_W-1:0] since_stop;
    ess_state_type next_state;

    function automatic logic [SEC_W-1:0] dur(input int idx,
            input logic [NTIMERS*SEC_W-1:0] d);
        dur = d[idx*SEC_W +: SEC_W];
    endfunction

    // timer index for the current state
    logic [3:0] tsel;
    always_comb begin
        tsel = 4'(T_STAB);
        unique case (state)
            S_STOPPED: tsel = 4'(T_STOP);
            S_STANDBY: tsel = 4'(T_STBY);
            S_AUTO_START: tsel = 4'(T_ASTA);
            S_PRESTART1: tsel = 4'(T_PRE1);
            S_PRESTART2: tsel = 4'(T_PRE2);
            S_CRANK: tsel = 4'(T_CRNK);
            S_CRANK_REST: tsel = 4'(T_REST);
            S_WARMUP: tsel = 4'(T_WARM);
            S_FILL1: tsel = 4'(T_FIL1);
            S_FILL2: tsel = 4'(T_FIL2);
            S_AUTO_STOP: tsel = 4'(T_ASTO);
            S_COOLDOWN: tsel = 4'(T_COOL);
            S_ETS: tsel = 4'(T_ETS);
            S_SPINDOWN: tsel = 4'(T_SPIN);
            default: tsel = 4'(T_STAB);
        endcase
    end
    wire logic [SEC_W-1:0] limit = durations[32'(tsel)*SEC_W +: SEC_W];
    wire logic expired = (secs >= limit);
    wire logic skip_auto = ~auto_mode;
    wire logic start_cmd = p_start | (auto_mode & auto_req);
    wire logic stop_req = p_stop | (auto_mode & ~auto_req);

    // ==========================================================
    // next state
    // fixed order
    always_comb begin
        next_state = state;
        unique case (state)
            S_STABILIZE: if (expired) next_state = S_STOPPED;
            S_STOPPED: begin
                if (start_cmd) begin
                    next_state = engine_not_ready ? S_WAIT_START :
                        (auto_mode & ~p_start) ? S_AUTO_START : S_PRESTART1;
                end else if (expired && dur(T_STBY, durations) != '0) begin
                    next_state = S_STANDBY;
                end
            end
            S_STANDBY: begin
                if (start_cmd) next_state = S_STABILIZE;
                else if (expired) next_state = S_STABILIZE;
            end
            S_WAIT_START: if (!engine_not_ready) next_state = S_PRESTART1;
            S_AUTO_START: begin
                if (!auto_req || !auto_mode) next_state = S_STOPPED;
                else if (expired) next_state = S_PRESTART1;
            end
            S_PRESTART1: if (expired) next_state = S_SAFE_CHECK;
            S_SAFE_CHECK: if (safe_to_start) next_state = S_PRESTART2;
            S_PRESTART2: begin
                if (fault || !link_ok) next_state = S_FAULT;
                else if (expired) next_state = S_CRANK;
            end
            S_CRANK: begin
                if (engine_started) next_state = S_FALSE_CHK;
                else if (expired) next_state = S_CRANK_REST;
            end
            S_CRANK_REST: if (expired) next_state = S_CRANK;
            S_FALSE_CHK: next_state = above_cutout ?
                (skip_auto ? S_RUNNING : S_WARMUP) : S_CRANK_REST;
            S_WARMUP: if (expired || skip_auto) next_state = S_FILL1;
            S_FILL1: if (expired || fill1_reached || skip_auto) next_state = S_FILL2;
            S_FILL2: if (expired || fill2_reached || skip_auto) next_state = S_RUNNING;
            S_RUNNING: begin
                if (p_stop) next_state = skip_cool ? S_ETS : S_COOLDOWN;
                else if (stop_req) next_state = S_AUTO_STOP;
            end
            S_AUTO_STOP: begin
                if (p_stop) next_state = S_COOLDOWN;
                else if (auto_req) next_state = S_RUNNING;
                else if (expired) next_state = S_COOLDOWN;
            end
            S_COOLDOWN: if (expired || skip_auto || skip_cool) next_state = S_ETS;
            S_ETS: if (expired) next_state = S_SPINDOWN;
            S_SPINDOWN: if (expired) next_state = S_STABILIZE;
            S_FAULT: if (p_enter) next_state = S_STOPPED;
            default: next_state = S_STABILIZE;
        endcase
        if (p_stop && state != S_RUNNING && state != S_AUTO_STOP &&
                (state & (S_AUTO_START | S_PRESTART1 | S_SAFE_CHECK |
                S_PRESTART2 | S_CRANK | S_CRANK_REST | S_WAIT_START)) != '0) begin
            next_state = S_STOPPED;
        end
        if (next_state != state && next_state != S_STOPPED &&
                next_state != S_STANDBY && dur(T_CRNK, durations) == '0 &&
                next_state == S_CRANK) begin
            next_state = S_FALSE_CHK;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_STABILIZE;
            secs <= '0;
            k_start_d <= 1'b0;
            k_stop_d <= 1'b0;
            k_auto_d <= 1'b0;
            k_enter_d <= 1'b0;
        end else begin
            k_start_d <= k_start;
            k_stop_d <= k_stop;
            k_auto_d <= k_auto;
            k_enter_d <= p_enter ? 1'b1 : k_enter;
            state <= next_state;
            if (next_state != state) secs <= '0;
            else if (tick) secs <= secs + SEC_W'(1);
        end
    end

    // stop key double press and hold, auto mode only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_secs <= '0;
            since_stop <= '1;
            skip_cool <= 1'b0;
            stop_key_cmd <= 1'b0;
        end else begin
            hold_secs <= !k_stop ? '0 : (tick ? hold_secs + SEC_W'(1) : hold_secs);
            if (p_stop) since_stop <= '0;
            else if (tick && since_stop != '1) since_stop <= since_stop + SEC_W'(1);
            // double or held press; inclusive so a tick between presses can't hide it
            if (state == S_STOPPED || state == S_STABILIZE) skip_cool <= 1'b0;
            else if (auto_mode && ((p_stop && since_stop <= SEC_W'(DOUBLE_SECONDS)) ||
                    hold_secs >= SEC_W'(HOLD_SECONDS))) skip_cool <= 1'b1;
            if (p_stop && state != S_STOPPED) stop_key_cmd <= 1'b1;
            else if (state == S_STOPPED) stop_key_cmd <= 1'b0;
        end
    end

    // ==========================================================
    // mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            auto_mode <= 1'b0;
            confirm_pending <= 1'b0;
        end else begin
            if (stop_key_cmd && next_state == S_STOPPED && state != S_STOPPED) begin
                auto_mode <= 1'b0;
                confirm_pending <= 1'b0;
            end else if (p_auto) begin
                if (auto_mode) auto_mode <= 1'b0;
                else confirm_pending <= ~confirm_pending;
            end else if (confirm_pending && p_enter) begin
                auto_mode <= 1'b1;
                confirm_pending <= 1'b0;
            end
        end
    end
    // start key acts in both modes via start_cmd

    // ==========================================================
    // outputs
    wire logic in_pre2 = (state == S_PRESTART2);
    wire logic [SPEED_W-1:0] warm_clamped = (warmup_speed < min_speed) ?
        min_speed : warmup_speed;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prestart_out <= 1'b0;
            ecu_enable <= 1'b0;
            crank_out <= 1'b0;
            backlight_on <= 1'b1;
            heater_on <= 1'b1;
            transceiver_on <= 1'b1;
            speed_cmd <= '0;
            speed_cmd_valid <= 1'b0;
        end else begin
            if (next_state == S_PRESTART1 || next_state == S_PRESTART2) prestart_out <= 1'b1;
            else if (crank_through && (in_pre2 || state == S_CRANK ||
                    state == S_CRANK_REST) && !engine_started) prestart_out <= 1'b1;
            else prestart_out <= 1'b0;
            if (next_state == S_STABILIZE) ecu_enable <= 1'b1;
            else if (next_state == S_STANDBY || next_state == S_ETS ||
                    next_state == S_SPINDOWN) ecu_enable <= 1'b0;
            crank_out <= (next_state == S_CRANK);
            backlight_on <= (next_state != S_STANDBY);
            heater_on <= (next_state != S_STANDBY);
            transceiver_on <= (next_state != S_STANDBY);
            speed_cmd_valid <= auto_mode && next_state == S_WARMUP;
            speed_cmd <= warm_clamped;
        end
    end

    // ==========================================================
    // passcode entry and settings gate
    logic [1:0] digit_pos;
    wire logic [3:0] want = passcode[4'(12 - 4*digit_pos) +: 4];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            digit_pos <= 2'h0;
            code_entry <= CODE_CLEAR;
            unlocked <= 1'b0;
            setting_accept <= 1'b0;
        end else begin
            if (!menu_open) begin
                digit_pos <= 2'h0;
                code_entry <= CODE_CLEAR;
                unlocked <= 1'b0;
            end else if (p_enter && !unlocked && !confirm_pending) begin
                if (digit_value != want) begin
                    digit_pos <= 2'h0;
                    code_entry <= CODE_CLEAR;
                end else begin
                    code_entry[4'(12 - 4*digit_pos) +: 4] <= digit_value;
                    digit_pos <= digit_pos + 2'h1;
                    if (digit_pos == 2'(DIGITS - 1)) unlocked <= 1'b1;
                end
            end
            setting_accept <= setting_write && unlocked &&
                (state == S_STOPPED || aftertreat_menu);
        end
    end
endmodule

// ### verif/ess_seq_asserts.sv
/* Concurrent checks on the start/stop sequencer top ports.
   Assumes binding to ess_sequencer, one clock and reset rst_b. */
`timescale 1ns/1ps
module ess_seq_asserts
    import ess_pkg::*;
#(
    parameter int SPEED_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // sequencer state and outputs
    input wire ess_state_type state,
    input wire logic auto_mode,
    input wire logic prestart_out,
    input wire logic ecu_enable,
    input wire logic backlight_on,
    input wire logic heater_on,
    input wire logic transceiver_on,
    input wire logic [SPEED_W-1:0] speed_cmd,
    input wire logic speed_cmd_valid,
    input wire logic unlocked,
    input wire logic setting_accept,
    // inputs that qualify the checks
    input wire logic crank_through,
    input wire logic engine_not_ready,
    input wire logic safe_to_start,
    input wire logic engine_started,
    input wire logic aftertreat_menu,
    input wire logic [SPEED_W-1:0] min_speed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // state checks
    sequence s_crank_exit;
        $past(state) == S_CRANK && state != S_CRANK;
    endsequence
    a_pre1_drives: assert property (state == S_PRESTART1 |-> prestart_out)
        else $error("prestart low in first delay");
    a_through_hold: assert property (state == S_CRANK && crank_through |-> prestart_out)
        else $error("prestart dropped while cranking through");
    a_standby_dark: assert property (state == S_STANDBY |->
        !backlight_on && !heater_on && !transceiver_on) else $error("standby still powered");
    a_standby_ecu: assert property (state == S_STANDBY |-> !ecu_enable)
        else $error("unit enable on in standby");
    a_wait_hold: assert property (state == S_WAIT_START && engine_not_ready
        |=> state == S_WAIT_START) else $error("left wait while not ready");
    a_check_hold: assert property (state == S_SAFE_CHECK && !safe_to_start
        |=> state == S_SAFE_CHECK) else $error("left check while unsafe");
    a_crank_rest: assert property (s_crank_exit |->
        $past(engine_started) || state == S_CRANK_REST) else $error("failed crank skipped rest");
    a_warm_clamp: assert property (speed_cmd_valid |-> auto_mode && speed_cmd >= min_speed)
        else $error("warm-up speed below minimum");
    a_manual_skip: assert property (!auto_mode |->
        !(state inside {S_AUTO_START, S_WARMUP, S_FILL1, S_FILL2})) else $error("auto state in manual");
    a_setting_gate: assert property (setting_accept |-> $past(unlocked) &&
        ($past(state) == S_STOPPED || $past(aftertreat_menu))) else $error("setting taken while locked");
endmodule
bind ess_sequencer ess_seq_asserts #(.SPEED_W(SPEED_W)) u_chk (.*);

// ### verif/ess_engine_model.sv
/* Behavioural engine and control unit facing the sequencer.
   Assumes the bench sets crank_need; the unit is powered by ecu_enable. */
`timescale 1ns/1ps
module ess_engine_model
    import ess_pkg::*;
#(
    parameter int NOT_READY = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // from the sequencer
    input wire logic ecu_enable,
    input wire logic crank_out,
    // crank cycles needed before the engine fires
    input wire logic [7:0] crank_need,
    // engine status
    output logic engine_not_ready,
    output logic safe_to_start,
    output logic engine_started,
    output logic above_cutout,
    output logic link_ok,
    output logic fill1_reached,
    output logic fill2_reached
);
    logic [7:0] up;
    logic [7:0] cranked;
    logic [7:0] ran;
    logic run;
    // ==========================================================
    // engine dies with the unit supply
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            up <= 8'h00;
            cranked <= 8'h00;
            ran <= 8'h00;
            run <= 1'b0;
        end else if (!ecu_enable) begin
            up <= 8'h00;
            cranked <= 8'h00;
            ran <= 8'h00;
            run <= 1'b0;
        end else begin
            if (up != 8'hFF) up <= up + 8'h01;
            if (crank_out) cranked <= cranked + 8'h01;
            if (crank_out && cranked + 8'h01 >= crank_need) run <= 1'b1;
            if (run && ran != 8'hFF) ran <= ran + 8'h01;
        end
    end
    // not ready while the unit boots
    assign engine_not_ready = ecu_enable && up < 8'(NOT_READY);
    assign safe_to_start = ecu_enable && !engine_not_ready;
    // speed stays above cutout once fired
    assign engine_started = run;
    assign above_cutout = run;
    assign link_ok = ecu_enable;
    // first fill early, second left to its timer
    assign fill1_reached = ran >= 8'h14;
    assign fill2_reached = ran == 8'hFF;
endmodule

// ### verif/ess_sequencer_tb.sv
/* Self-checking bench for the start/stop sequencer with the engine model.
   Assumes TICK shortened to 10 clocks, so one second is ten cycles. */
`timescale 1ns/1ps
module ess_sequencer_tb
    import ess_pkg::*;
();
    logic clk, rst_b, auto_start_pin, menu_open, aftertreat_menu, setting_write;
    logic crank_through, fault;
    logic [3:0] keys;
    logic [3:0] digit_value;
    logic [NTIMERS*SEC_W-1:0] durations;
    logic [7:0] crank_need;
    logic engine_not_ready, safe_to_start, engine_started, above_cutout;
    logic link_ok, fill1_reached, fill2_reached;
    ess_state_type state;
    logic auto_mode, prestart_out, ecu_enable, crank_out, backlight_on, heater_on;
    logic transceiver_on, speed_cmd_valid, confirm_pending, unlocked, setting_accept;
    logic [15:0] speed_cmd;
    logic [15:0] code_entry;
    int error_cnt = 0;
    int tests_run = 0;
    int dv[NTIMERS] = '{1, 1, 0, 1, 1, 2, 1, 1, 2, 2, 5, 1, 1, 3, 1};
    int pin[7] = '{1, 2, 9, 1, 2, 3, 4};
    // ==========================================================
    // design and engine
    ess_sequencer #(.TICK(10), .SPEED_W(16)) uut (.*, .key_start_pin(keys[0]),
        .key_stop_pin(keys[1]), .key_auto_pin(keys[2]), .key_enter_pin(keys[3]),
        .passcode(16'h1234), .warmup_speed(16'h0100), .min_speed(16'h0200));
    ess_engine_model u_eng (.*);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==========================================================
    // shared tasks
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic press(input int k);
        keys[k] = 1'b1;
        cyc(8);
        keys[k] = 1'b0;
        cyc(8);
    endtask
    task automatic wait_st(input ess_state_type s);
        for (int i = 0; i < 400 && state !== s; i++) cyc(1);
        chk("state", state, s);
    endtask
    task automatic setw(input int e);
        int n;
        n = 0;
        setting_write = 1'b1;
        cyc(1);
        setting_write = 1'b0;
        repeat (4) begin
            if (setting_accept === 1'b1) n++;
            cyc(1);
        end
        chk("accept", n, e);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_passcode();
        menu_open = 1'b1;
        for (int i = 0; i < 7; i++) begin
            digit_value = 4'(pin[i]);
            press(3);
            if (i == 2) chk("entry", code_entry, 16'h0000);
        end
        chk("unlocked", unlocked, 1'b1);
        setw(1);
    endtask
    task automatic t_manual();
        crank_need = 8'h1E;
        keys[0] = 1'b1;
        wait_st(S_PRESTART1);
        keys[0] = 1'b0;
        chk("prestart", prestart_out, 1'b1);
        wait_st(S_SAFE_CHECK);
        chk("prestart", prestart_out, 1'b0);
        wait_st(S_CRANK_REST);
        chk("crank", crank_out, 1'b0);
        wait_st(S_RUNNING);
        chk("speed_valid", speed_cmd_valid, 1'b0);
        setw(0);
        aftertreat_menu = 1'b1;
        setw(1);
        aftertreat_menu = 1'b0;
        cyc(50);
        chk("state", state, S_RUNNING);
        press(1);
        wait_st(S_STOPPED);
        menu_open = 1'b0;
    endtask
    task automatic t_fault();
        fault = 1'b1;
        press(0);
        wait_st(S_FAULT);
        fault = 1'b0;
        press(3);
        chk("state", state, S_STOPPED);
    endtask
    task automatic t_standby();
        durations[T_STBY*SEC_W +: SEC_W] = SEC_W'(1);
        wait_st(S_STANDBY);
        chk("power", {backlight_on, heater_on, transceiver_on}, 3'h0);
        chk("ecu", ecu_enable, 1'b0);
        wait_st(S_STABILIZE);
        chk("ecu", ecu_enable, 1'b1);
    endtask
    task automatic t_mode();
        press(2);
        chk("pending", confirm_pending, 1'b1);
        chk("auto", auto_mode, 1'b0);
        press(3);
        chk("auto", auto_mode, 1'b1);
    endtask
    task automatic t_abort();
        // request shorter than the three second delay
        auto_start_pin = 1'b1;
        cyc(15);
        auto_start_pin = 1'b0;
        cyc(30);
        chk("state", state, S_STOPPED);
    endtask
    task automatic t_auto_run();
        crank_need = 8'h05;
        crank_through = 1'b1;
        auto_start_pin = 1'b1;
        wait_st(S_AUTO_START);
        wait_st(S_CRANK);
        chk("prestart", prestart_out, 1'b1);
        wait_st(S_WARMUP);
        chk("prestart", prestart_out, 1'b0);
        chk("speed", speed_cmd, 16'h0200);
        chk("speed_valid", speed_cmd_valid, 1'b1);
        wait_st(S_FILL1);
        wait_st(S_FILL2);
        wait_st(S_RUNNING);
    endtask
    task automatic t_stop_skip();
        int seen;
        seen = 0;
        // double press must cut the five second cooldown short
        for (int i = 0; i < 400 && state !== S_STOPPED; i++) begin
            keys[1] = (i < 4) || (i >= 8 && i < 12);
            if (state === S_COOLDOWN) seen++;
            cyc(1);
        end
        keys[1] = 1'b0;
        chk("cooldown", seen < 12, 1'b1);
        chk("auto", auto_mode, 1'b0);
        cyc(60);
        chk("state", state, S_STOPPED);
        auto_start_pin = 1'b0;
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        rst_b = 1'b0;
        keys = 4'h0;
        auto_start_pin = 1'b0;
        digit_value = 4'h0;
        menu_open = 1'b0;
        aftertreat_menu = 1'b0;
        setting_write = 1'b0;
        crank_through = 1'b0;
        fault = 1'b0;
        crank_need = 8'h1E;
        for (int j = 0; j < NTIMERS; j++) durations[j*SEC_W +: SEC_W] = SEC_W'(dv[j]);
        cyc(8);
        chk("state", state, S_STABILIZE);
        chk("power", {backlight_on, heater_on, transceiver_on}, 3'h7);
        rst_b = 1'b1;
        wait_st(S_STOPPED);
        chk("ecu", ecu_enable, 1'b1);
        t_passcode();
        t_manual();
        t_fault();
        t_mode();
        t_abort();
        t_auto_run();
        t_stop_skip();
        t_standby();
        summarize();
    end
    initial begin
        // whole run needs under a thousand cycles
        cyc(20000);
        error_cnt++;
        summarize();
    end
endmodule
